// ===== core/tsp_cfg.svh
/*
 * constants of the two-wire register port: slave address, byte framing, pointer range.
 * assumes inclusion by the package, the design modules and the bench, by bare name.
 */
`ifndef TSP_CFG_SVH
`define TSP_CFG_SVH
// ----------------------------------------
// addressing
// ----------------------------------------
`define TSP_DEV_ADDR_HI 5'h0B
`define TSP_PTR_W 8
`define TSP_PTR_RST 8'h00
`define TSP_PTR_LAST 8'h3F
`define TSP_PTR_ONE 8'h01
// ----------------------------------------
// framing
// ----------------------------------------
`define TSP_CNT_W 4
`define TSP_CNT_ZERO 4'h0
`define TSP_CNT_ONE 4'h1
`define TSP_BITS_BYTE 4'h8
`define TSP_BITS_LAST 4'h7
`define TSP_BYTE_RST 8'h00
`define TSP_WORD_RST 16'h0000
// scl and sda come out of reset high like an idle bus, so reset shows no false edge
`define TSP_SYNC_RST 4'hC
`endif

// ===== core/tsp_pkg.sv
/*
 * types of the two-wire register port: state codes and the packed state record.
 * assumes tsp_cfg.svh is on the include path.
 */
`include "tsp_cfg.svh"
package tsp_pkg;
	typedef enum logic [6:0] {
		TSP_IDLE = 7'h01,
		TSP_ADDR = 7'h02,
		TSP_AACK = 7'h04,
		TSP_RX = 7'h08,
		TSP_RACK = 7'h10,
		TSP_TX = 7'h20,
		TSP_TACK = 7'h40
	} tsp_state_t;

	typedef struct packed {
		tsp_state_t st;
		logic scl_d;
		logic sda_d;
		logic [`TSP_CNT_W-1:0] cnt;
		logic [7:0] shift;
		logic rw;
		logic nack;
		logic [1:0] bidx;
		logic tx_lo;
		logic [7:0] lo;
		logic [7:0] hi;
		logic exh;
		logic [`TSP_PTR_W-1:0] ptr;
		logic [`TSP_PTR_W-1:0] wr_addr;
		logic [15:0] wr_data;
		logic wr_en;
		logic sda_oe_n;
		logic sda_out;
	} tsp_regs_t;

	typedef struct packed {
		logic [3:0] meta;
		logic [3:0] sync;
	} tsp_sync_regs_t;
endpackage

// ===== core/tsp_sync.sv
/*
 * two-stage synchroniser for the pin inputs of the register port.
 * assumes inputs are asynchronous to clk_sys; only the second stage is read outside.
 */
`timescale 1ns/1ps
`include "tsp_cfg.svh"
module tsp_sync (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [3:0] pin_raw,
	output logic [3:0] pin_sync
);
	import tsp_pkg::*;

	tsp_sync_regs_t r_ff;
	tsp_sync_regs_t nxt_r;

	// the first stage may go metastable, so only the second one leaves this module
	always_comb begin
		nxt_r.meta = pin_raw;
		nxt_r.sync = r_ff.meta;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			r_ff.meta <= `TSP_SYNC_RST;
			r_ff.sync <= `TSP_SYNC_RST;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign pin_sync = r_ff.sync;
endmodule

// ===== core/tsp_i2c_slave.sv
/*
 * two-wire slave port giving a bus master access to a bank of 16-bit registers.
 * assumes scl, sda and straps are asynchronous pins, the register bank answers
 * reg_rd_data combinationally from reg_addr, and scl is far slower than clk_sys.
 */
//
// Behaviour
// - bytes are eight bits, msb first
// - sda falling while scl high starts
// - shift in seven address bits plus direction
// - matching address acknowledged low on ninth pulse
// - mismatch releases sda until next start
// - direction zero writes, one reads
// - nine pulses per byte, device acks writes
// - sda changes only while scl low
// - no limit on bytes per transaction
// - stop returns to idle at once
// - first written byte loads address pointer
// - high data byte, then low byte
// - pointer advances after each register write
// - no wrap; writes past last discarded
// - registers written from byte pairs
// - read returns high byte then low
// - pointer advances per read until nack
// - at last address, repeat last register
// - address 01011 plus two strap bits
// - slave only, never starts transfers
`timescale 1ns/1ps
`include "tsp_cfg.svh"
module tsp_i2c_slave (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic scl,
	input wire logic sda,
	output logic sda_drv,
	output logic sda_oe_n,
	input wire logic slave_addr_strap_hi,
	input wire logic slave_addr_strap_lo,
	output logic [`TSP_PTR_W-1:0] reg_addr,
	input wire logic [15:0] reg_rd_data,
	output logic reg_wr_en,
	output logic [`TSP_PTR_W-1:0] reg_wr_addr,
	output logic [15:0] reg_wr_data
);
	import tsp_pkg::*;

	// ----------------------------------------
	// pin sampling
	// ----------------------------------------
	logic [3:0] pin_s;
	logic scl_s;
	logic sda_s;
	logic strap_hi_s;
	logic strap_lo_s;

	// bus pins and straps share one synchroniser so scl and sda keep their relative order
	tsp_sync u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.pin_raw({scl, sda, slave_addr_strap_hi, slave_addr_strap_lo}),
		.pin_sync(pin_s)
	);
	assign {scl_s, sda_s, strap_hi_s, strap_lo_s} = pin_s;

	tsp_regs_t r_ff;
	tsp_regs_t nxt_r;

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic addr_match;

	assign scl_rise = scl_s && !r_ff.scl_d;
	assign scl_fall = !scl_s && r_ff.scl_d;
	assign start_det = scl_s && r_ff.scl_d && r_ff.sda_d && !sda_s;
	assign stop_det = scl_s && r_ff.scl_d && !r_ff.sda_d && sda_s;
	assign addr_match = r_ff.shift[7:1] == {`TSP_DEV_ADDR_HI, strap_hi_s, strap_lo_s};

	// pointer stops at the last register instead of wrapping
	function automatic logic [`TSP_PTR_W-1:0] ptr_step(input logic [`TSP_PTR_W-1:0] p);
		ptr_step = (p == `TSP_PTR_LAST) ? p : p + `TSP_PTR_ONE;
	endfunction

	// ----------------------------------------
	// protocol engine
	// ----------------------------------------
	always_comb begin
		nxt_r = r_ff;
		nxt_r.scl_d = scl_s;
		nxt_r.sda_d = sda_s;
		nxt_r.wr_en = 1'b0;
		nxt_r.sda_out = 1'b0; // open drain: only ever pulls low
		if (stop_det) begin
			nxt_r.st = TSP_IDLE;
			nxt_r.sda_oe_n = 1'b1; // pointer kept for a later read
		end else if (start_det) begin
			nxt_r.st = TSP_ADDR; // repeated start also lands here
			nxt_r.cnt = `TSP_CNT_ZERO;
			nxt_r.sda_oe_n = 1'b1;
		end else begin
			case (r_ff.st)
				TSP_IDLE: begin
					nxt_r.sda_oe_n = 1'b1;
				end
				TSP_ADDR, TSP_RX: begin
					if (scl_rise && r_ff.cnt != `TSP_BITS_BYTE) begin
						nxt_r.shift = {r_ff.shift[6:0], sda_s};
						nxt_r.cnt = r_ff.cnt + `TSP_CNT_ONE;
					end else if (scl_fall && r_ff.cnt == `TSP_BITS_BYTE) begin
						if (r_ff.st == TSP_ADDR) begin
							if (addr_match) begin
								nxt_r.st = TSP_AACK;
								nxt_r.sda_oe_n = 1'b0;
								nxt_r.rw = r_ff.shift[0];
							end else begin
								nxt_r.st = TSP_IDLE;
							end
						end else begin
							nxt_r.st = TSP_RACK;
							nxt_r.sda_oe_n = 1'b0; // every written byte is acked
							case (r_ff.bidx)
								2'h0: begin
									nxt_r.ptr = r_ff.shift;
									nxt_r.exh = 1'b0;
									nxt_r.bidx = 2'h1;
								end
								2'h1: begin
									nxt_r.hi = r_ff.shift;
									nxt_r.bidx = 2'h2;
								end
								default: begin
									nxt_r.bidx = 2'h1;
									if (!r_ff.exh) begin
										nxt_r.wr_en = 1'b1;
										nxt_r.wr_addr = r_ff.ptr;
										nxt_r.wr_data = {r_ff.hi, r_ff.shift};
										nxt_r.ptr = ptr_step(r_ff.ptr);
										nxt_r.exh = r_ff.ptr == `TSP_PTR_LAST;
									end
								end
							endcase
						end
					end
				end
				TSP_AACK, TSP_RACK: begin
					if (scl_fall) begin // ack ends with the ninth pulse
						nxt_r.cnt = `TSP_CNT_ZERO;
						if (r_ff.st == TSP_AACK && r_ff.rw) begin
							nxt_r.st = TSP_TX;
							nxt_r.tx_lo = 1'b1;
							nxt_r.shift = reg_rd_data[15:8];
							nxt_r.lo = reg_rd_data[7:0];
							nxt_r.sda_oe_n = reg_rd_data[15];
						end else begin
							nxt_r.st = TSP_RX;
							nxt_r.sda_oe_n = 1'b1;
							if (r_ff.st == TSP_AACK) begin
								nxt_r.bidx = 2'h0;
							end
						end
					end
				end
				TSP_TX: begin
					if (scl_fall) begin
						nxt_r.cnt = r_ff.cnt + `TSP_CNT_ONE;
						if (r_ff.cnt == `TSP_BITS_LAST) begin
							nxt_r.st = TSP_TACK;
							nxt_r.sda_oe_n = 1'b1;
						end else begin
							nxt_r.shift = {r_ff.shift[6:0], 1'b0};
							nxt_r.sda_oe_n = r_ff.shift[6];
						end
					end
				end
				TSP_TACK: begin
					if (scl_rise) begin
						nxt_r.nack = sda_s;
					end else if (scl_fall) begin
						nxt_r.cnt = `TSP_CNT_ZERO;
						if (r_ff.nack) begin
							nxt_r.st = TSP_IDLE;
						end else begin
							nxt_r.st = TSP_TX;
							if (r_ff.tx_lo) begin
								nxt_r.tx_lo = 1'b0;
								nxt_r.shift = r_ff.lo;
								nxt_r.sda_oe_n = r_ff.lo[7];
								nxt_r.ptr = ptr_step(r_ff.ptr);
							end else begin
								nxt_r.tx_lo = 1'b1;
								nxt_r.shift = reg_rd_data[15:8];
								nxt_r.lo = reg_rd_data[7:0];
								nxt_r.sda_oe_n = reg_rd_data[15];
							end
						end
					end
				end
				default: begin
					nxt_r.st = TSP_IDLE;
					nxt_r.sda_oe_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			r_ff.st <= TSP_IDLE;
			r_ff.scl_d <= 1'b1;
			r_ff.sda_d <= 1'b1;
			r_ff.cnt <= `TSP_CNT_ZERO;
			r_ff.shift <= `TSP_BYTE_RST;
			r_ff.rw <= 1'b0;
			r_ff.nack <= 1'b0;
			r_ff.bidx <= 2'h0;
			r_ff.tx_lo <= 1'b0;
			r_ff.lo <= `TSP_BYTE_RST;
			r_ff.hi <= `TSP_BYTE_RST;
			r_ff.exh <= 1'b0;
			r_ff.ptr <= `TSP_PTR_RST;
			r_ff.wr_addr <= `TSP_PTR_RST;
			r_ff.wr_data <= `TSP_WORD_RST;
			r_ff.wr_en <= 1'b0;
			r_ff.sda_oe_n <= 1'b1;
			r_ff.sda_out <= 1'b0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign sda_drv = r_ff.sda_out;
	assign sda_oe_n = r_ff.sda_oe_n;
	assign reg_addr = r_ff.ptr;
	assign reg_wr_en = r_ff.wr_en;
	assign reg_wr_addr = r_ff.wr_addr;
	assign reg_wr_data = r_ff.wr_data;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_addr_done;
		r_ff.st == TSP_ADDR && scl_fall && r_ff.cnt == `TSP_BITS_BYTE && !start_det && !stop_det;
	endsequence

	sequence s_data_done;
		r_ff.st == TSP_RX && scl_fall && r_ff.cnt == `TSP_BITS_BYTE && !start_det && !stop_det;
	endsequence

	AST_START_ADDR: assert property (@(posedge clk_sys) disable iff (!resetn)
		start_det && !stop_det |=> r_ff.st == TSP_ADDR && r_ff.cnt == `TSP_CNT_ZERO)
		else $error("start not followed by address phase");

	AST_STOP_IDLE: assert property (@(posedge clk_sys) disable iff (!resetn)
		stop_det |=> r_ff.st == TSP_IDLE && r_ff.sda_oe_n)
		else $error("stop did not return to idle");

	AST_ACK_MATCH: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_addr_done and addr_match |=> !r_ff.sda_oe_n && r_ff.st == TSP_AACK)
		else $error("matching address not acknowledged");

	AST_NO_MATCH: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_addr_done and !addr_match |=> r_ff.st == TSP_IDLE ##1 r_ff.sda_oe_n)
		else $error("foreign address touched sda");

	AST_SDA_STABLE: assert property (@(posedge clk_sys) disable iff (!resetn)
		scl_s && $past(scl_s) && !$past(start_det) && !$past(stop_det) |-> $stable(r_ff.sda_oe_n))
		else $error("sda drive changed while scl high");

	AST_PTR_LOAD: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_data_done and r_ff.bidx == 2'h0 |=> reg_addr == $past(r_ff.shift) && !reg_wr_en)
		else $error("register address byte not loaded");

	AST_WR_PAIR: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_data_done and r_ff.bidx == 2'h2 and !r_ff.exh |=>
		reg_wr_en && reg_wr_addr == $past(r_ff.ptr) && reg_wr_data == {$past(r_ff.hi), $past(r_ff.shift)}
		&& reg_addr == ptr_step($past(r_ff.ptr)) ##1 !reg_wr_en)
		else $error("register write or pointer step wrong");

	AST_NO_WRAP: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_data_done and r_ff.bidx == 2'h2 and r_ff.exh |=> !reg_wr_en && reg_addr == `TSP_PTR_LAST)
		else $error("write past last register not discarded");

	AST_RX_ACK: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_data_done |=> r_ff.st == TSP_RACK && !r_ff.sda_oe_n)
		else $error("written byte not acknowledged");

	AST_ACK_RELEASE: assert property (@(posedge clk_sys) disable iff (!resetn)
		r_ff.st == TSP_RACK && scl_fall && !start_det && !stop_det |=> r_ff.st == TSP_RX && r_ff.sda_oe_n)
		else $error("acknowledge not released after ninth pulse");

	AST_NACK_IDLE: assert property (@(posedge clk_sys) disable iff (!resetn)
		r_ff.st == TSP_TACK && scl_fall && r_ff.nack && !start_det && !stop_det
		|=> r_ff.st == TSP_IDLE && r_ff.sda_oe_n)
		else $error("read not ended by master nack");

	AST_READ_HI: assert property (@(posedge clk_sys) disable iff (!resetn)
		r_ff.st == TSP_AACK && r_ff.rw && scl_fall && !start_det && !stop_det |=>
		r_ff.shift == $past(reg_rd_data[15:8]) && r_ff.lo == $past(reg_rd_data[7:0]))
		else $error("read did not start with high byte");

	AST_READ_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
		r_ff.st == TSP_TACK && scl_fall && r_ff.tx_lo && !r_ff.nack && r_ff.ptr == `TSP_PTR_LAST
		&& !start_det && !stop_det |=> reg_addr == `TSP_PTR_LAST)
		else $error("read pointer wrapped");
endmodule

// ===== tb/tsp_master_model.sv
/*
 * bus master model for the two-wire register port: start, stop, bytes out and in.
 * assumes the bench resolves the open-drain wire with a pull-up and feeds it back on sda.
 */
`timescale 1ns/1ps
module tsp_master_model (
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	// ----------------------------------------
	// clock and data phases, 160 ns per bit
	// ----------------------------------------
	// scl stands high between frames; nothing moves until a task runs
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// data moves only in the low phase of scl
	task automatic bit_out(input logic b);
		#20 sda_pull = ~b;
		#60 scl = 1'b1;
		#80 scl = 1'b0;
	endtask
	task automatic bit_in(output logic b);
		#20 sda_pull = 1'b0;
		#60 scl = 1'b1;
		#40 b = sda;
		#40 scl = 1'b0;
	endtask
	// serves as first and as repeated start
	task automatic start();
		#20 sda_pull = 1'b0;
		#60 scl = 1'b1;
		#40 sda_pull = 1'b1;
		#40 scl = 1'b0;
	endtask
	task automatic stop();
		#20 sda_pull = 1'b1;
		#60 scl = 1'b1;
		#40 sda_pull = 1'b0;
		#40;
	endtask
	// eight bits msb first, ninth pulse for the slave's acknowledge
	task automatic put_byte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_in(ack);
	endtask
	// a high acknowledge from the master ends a read
	task automatic get_byte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bit_in(d[i]);
		end
		bit_out(last);
	endtask
endmodule

// ===== tb/tsp_i2c_slave_tb_top.sv
/*
 * self-checking bench of the two-wire register port with a small register bank.
 * assumes the master model drives scl and its pull on sda; the wire has a pull-up.
 */
`timescale 1ns/1ps
`include "tsp_cfg.svh"
module tsp_i2c_slave_tb_top;
	import tsp_pkg::*;
	logic clk_sys, resetn, scl, sda_pull, sda, sda_drv, sda_oe_n, reg_wr_en;
	logic slave_addr_strap_hi, slave_addr_strap_lo;
	logic [`TSP_PTR_W-1:0] reg_addr, reg_wr_addr;
	logic [15:0] reg_rd_data, reg_wr_data;
	logic [15:0] mem [0:63];
	int miscompares = 0;
	int n_compared = 0;
	int n_wr = 0;
	int cycles = 0;
	// ----------------------------------------
	// wire, bank and device
	// ----------------------------------------
	// open drain: low if either side pulls, pull-up otherwise
	assign sda = ~(sda_pull | (~sda_oe_n & ~sda_drv));
	assign reg_rd_data = mem[reg_addr[5:0]];
	tsp_master_model i_master (.scl(scl), .sda_pull(sda_pull), .sda(sda));
	tsp_i2c_slave i_dut (.clk_sys(clk_sys), .resetn(resetn), .scl(scl), .sda(sda),
		.sda_drv(sda_drv), .sda_oe_n(sda_oe_n), .slave_addr_strap_hi(slave_addr_strap_hi),
		.slave_addr_strap_lo(slave_addr_strap_lo), .reg_addr(reg_addr), .reg_rd_data(reg_rd_data),
		.reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// bound well above the four scenarios, some 6000 cycles
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (reg_wr_en === 1'b1) begin
			mem[reg_wr_addr[5:0]] <= reg_wr_data;
			n_wr <= n_wr + 1;
		end
		if (cycles == 20000) begin
			miscompares++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({15'h0000, got}, {15'h0000, exp});
	endtask
	// ----------------------------------------
	// helpers and scenarios
	// ----------------------------------------
	task automatic settle();
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	task automatic send(input logic [7:0] d);
		logic a;
		i_master.put_byte(d, a);
		chk_bit(a, 1'b0);
	endtask
	task automatic recv(input logic last, input logic [15:0] exp);
		logic [7:0] h, l;
		i_master.get_byte(1'b0, h);
		i_master.get_byte(last, l);
		chk_word({h, l}, exp);
	endtask
	task automatic t_addr();
		logic a;
		for (int s = 0; s < 4; s++) begin
			settle();
			{slave_addr_strap_hi, slave_addr_strap_lo} = 2'(s);
			settle();
			i_master.start();
			i_master.put_byte({5'h0B, 2'(s), 1'b0}, a);
			chk_bit(a, 1'b0);
			i_master.start();
			i_master.put_byte({5'h0B, 2'(s ^ 1), 1'b1}, a);
			chk_bit(a, 1'b1);
			i_master.stop();
		end
	endtask
	task automatic t_write();
		int w0;
		w0 = n_wr;
		i_master.start();
		send(8'h5E);
		send(8'h10);
		send(8'h12);
		send(8'h34);
		send(8'hAB);
		send(8'hCD);
		send(8'h77);
		i_master.stop();
		settle();
		chk_word(mem[16], 16'h1234);
		chk_word(mem[17], 16'hABCD);
		chk_word(16'(n_wr - w0), 16'h0002);
		chk_word(16'(reg_addr), 16'h0012);
		chk_bit(sda_oe_n, 1'b1);
		chk_bit(sda_drv, 1'b0);
		chk_word(16'(reg_wr_addr), 16'h0011);
		chk_word(reg_wr_data, 16'hABCD);
	endtask
	task automatic t_edge();
		int w0;
		w0 = n_wr;
		i_master.start();
		send(8'h5E);
		send(8'h3E);
		send(8'h11);
		send(8'h22);
		send(8'h33);
		send(8'h44);
		send(8'h55);
		send(8'h66);
		i_master.stop();
		settle();
		chk_word(mem[62], 16'h1122);
		chk_word(mem[63], 16'h3344);
		chk_word(16'(n_wr - w0), 16'h0002);
		i_master.start();
		send(8'h5E);
		send(8'h3E);
		// repeated start, the pointer must survive it
		i_master.start();
		send(8'h5F);
		recv(1'b0, 16'h1122);
		recv(1'b0, 16'h3344);
		recv(1'b1, 16'h3344);
		i_master.stop();
	endtask
	task automatic t_abort();
		int w0;
		w0 = n_wr;
		i_master.start();
		send(8'h5E);
		send(8'h20);
		send(8'h55);
		for (int i = 0; i < 4; i++) begin
			i_master.bit_out(1'b1);
		end
		i_master.stop();
		settle();
		chk_word(16'(n_wr - w0), 16'h0000);
		chk_bit(sda_oe_n, 1'b1);
		i_master.start();
		send(8'h5F);
		recv(1'b1, 16'hC0DE);
		i_master.stop();
	endtask
	initial begin
		for (int i = 0; i < 64; i++) begin
			mem[i] = 16'(i);
		end
		mem[32] = 16'hC0DE;
		resetn = 1'b0;
		slave_addr_strap_hi = 1'b0;
		slave_addr_strap_lo = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 resetn = 1'b1;
		settle();
		chk_word(16'(reg_addr), 16'h0000);
		chk_bit(sda_oe_n, 1'b1);
		t_addr();
		t_write();
		t_edge();
		t_abort();
		give_verdict();
	end
endmodule
